// File: core/pcs_flow_core.sv
`timescale 1ns/1ps
module pcs_flow_core
    import pcs_pkg::*;
(
    // Clock and reset
    clk,
    rst_n,
    // Program flow requests from execution
    pc_step,
    pcl_wr,
    pcl_wdata,
    latch_wr,
    latch_wdata,
    jump_go,
    call_go,
    jump_addr,
    intr_go,
    ret_go,
    return_with_literal_go,
    return_from_interrupt_go,
    // Pointer and bank select
    fsr_wr,
    fsr_wdata,
    indirect_bank_select,
    // Register file access requests
    acc_req,
    acc_wr,
    acc_addr,
    // Program counter and registers
    pc_q,
    pc_high_latch_q,
    file_select_pointer_q,
    // Resolved register file access
    file_addr_q,
    file_rd_en_q,
    file_wr_en_q,
    file_rd_zero_q
);

    input  wire logic                   clk;
    input  wire logic                   rst_n;
    input  wire logic                   pc_step;
    input  wire logic                   pcl_wr;
    input  wire logic [BYTE_W-1:0]      pcl_wdata;
    input  wire logic                   latch_wr;
    input  wire logic [UPPER_W-1:0]     latch_wdata;
    input  wire logic                   jump_go;
    input  wire logic                   call_go;
    input  wire logic [JUMP_W-1:0]      jump_addr;
    input  wire logic                   intr_go;
    input  wire logic                   ret_go;
    input  wire logic                   return_with_literal_go;
    input  wire logic                   return_from_interrupt_go;
    input  wire logic                   fsr_wr;
    input  wire logic [BYTE_W-1:0]      fsr_wdata;
    input  wire logic                   indirect_bank_select;
    input  wire logic                   acc_req;
    input  wire logic                   acc_wr;
    input  wire logic [FILE_ADDR_W-1:0] acc_addr;
    output logic      [PC_W-1:0]        pc_q;
    output logic      [UPPER_W-1:0]     pc_high_latch_q;
    output logic      [BYTE_W-1:0]      file_select_pointer_q;
    output logic      [FILE_ADDR_W-1:0] file_addr_q;
    output logic                        file_rd_en_q;
    output logic                        file_wr_en_q;
    output logic                        file_rd_zero_q;

    ////////////////////////////////////////////////////////////////////////////////

    logic [PC_W-1:0]        pc_d;
    logic [PC_W-1:0]        stk_top;
    logic [PC_W-1:0]        jump_target;
    logic [PC_W-1:0]        pcl_target;
    logic [UPPER_W-1:0]     pc_upper_bits;
    logic [BYTE_W-1:0]      pc_low_byte;
    logic                   push_go;
    logic                   pop_any;
    logic                   pop_go;
    logic                   page_go;
    logic                   is_indirect;
    logic                   ind_self;
    logic [FILE_ADDR_W-1:0] ind_addr;
    logic [FILE_ADDR_W-1:0] file_addr_d;
    logic                   file_rd_en_d;
    logic                   file_wr_en_d;
    logic                   file_rd_zero_d;

    // Stack events; a push beats a pop if the core ever raises both
    assign push_go = intr_go | call_go;
    assign pop_any = ret_go | return_with_literal_go | return_from_interrupt_go;
    assign pop_go  = pop_any & ~push_go;
    assign page_go = call_go | jump_go;

    // Upper bits live only inside pc_q; so does the readable low byte, its bottom eight bits
    assign pc_low_byte   = pc_q[BYTE_W-1:0];
    assign pc_upper_bits = pc_q[PC_W-1:BYTE_W];

    // Candidate loads of the counter
    assign jump_target = {pc_high_latch_q[PAGE_HI:PAGE_LO], jump_addr};
    assign pcl_target  = {pc_high_latch_q, pcl_wdata};

    // Next counter, highest priority first
    assign pc_d = intr_go ? INTR_VECTOR
                : page_go ? jump_target
                : pop_go  ? stk_top
                : pcl_wr  ? pcl_target
                : pc_step ? pc_q + PC_STEP
                : pc_q;

    ////////////////////////////////////////////////////////////////////////////////

    // Return stack; the current counter is already the return address
    pcs_ret_stack u_stack (
        .clk       (clk),
        .rst_n     (rst_n),
        .push      (push_go),
        .pop       (pop_go),
        .push_data (pc_q),
        .top_data  (stk_top)
    );

    // Program counter; every reset clears the whole word
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_q <= PC_RESET;
        end else begin
            pc_q <= pc_d;
        end
    end

    // High latch changes only on its own write, never on push or pop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pc_high_latch_q <= LATCH_RESET;
        end else if (latch_wr) begin
            pc_high_latch_q <= latch_wdata;
        end
    end

    // Pointer register
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_select_pointer_q <= FSR_RESET;
        end else if (fsr_wr) begin
            file_select_pointer_q <= fsr_wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Indirect decode; the port has no storage, it only redirects the access
    assign is_indirect = acc_addr[FILE_LOW_W-1:0] == INDIRECT_REG;
    assign ind_addr    = {indirect_bank_select, file_select_pointer_q};
    assign ind_self    = is_indirect && file_select_pointer_q == SELF_PTR;
    assign file_addr_d = is_indirect ? ind_addr : acc_addr;

    // Self access: reads give zero, writes are dropped; flags stay with the core
    assign file_rd_en_d   = acc_req & ~acc_wr & ~ind_self;
    assign file_wr_en_d   = acc_req & acc_wr & ~ind_self;
    assign file_rd_zero_d = acc_req & ~acc_wr & ind_self;

    // Resolved access, one cycle behind the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            file_addr_q    <= '0;
            file_rd_en_q   <= 1'b0;
            file_wr_en_q   <= 1'b0;
            file_rd_zero_q <= 1'b0;
        end else begin
            file_addr_q    <= file_addr_d;
            file_rd_en_q   <= file_rd_en_d;
            file_wr_en_q   <= file_wr_en_d;
            file_rd_zero_q <= file_rd_zero_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    // Helper for checks: low after reset until the first edge
    logic started_q;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            started_q <= 1'b0;
        end else begin
            started_q <= 1'b1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_call;
        call_go && !intr_go;
    endsequence

    sequence s_return;
        pop_any && !push_go;
    endsequence

    a_reset_upper_clear: assert property (!started_q |-> pc_upper_bits == '0)
        else $error("upper counter bits not clear after reset");

    a_pcl_write_load: assert property (pcl_wr && !intr_go && !page_go && !pop_any
        |=> pc_q == {$past(pc_high_latch_q), $past(pcl_wdata)})
        else $error("low byte write did not load upper from latch");

    a_jump_page_bits: assert property (page_go && !intr_go
        |=> pc_q[PC_W-1:JUMP_W] == $past(pc_high_latch_q[PAGE_HI:PAGE_LO])
            && pc_q[JUMP_W-1:0] == $past(jump_addr))
        else $error("jump target page bits wrong");

    a_call_return_pair: assert property (s_call ##1 s_return
        |=> pc_q == $past(pc_q, 2))
        else $error("return did not restore pushed counter");

    a_intr_vector_ret: assert property (intr_go ##1 (return_from_interrupt_go && !push_go)
        |-> pc_q == INTR_VECTOR ##1 pc_q == $past(pc_q, 2))
        else $error("interrupt return did not restore counter");

    a_latch_kept_stack: assert property ((push_go || pop_any) && !latch_wr
        |=> pc_high_latch_q == $past(pc_high_latch_q))
        else $error("latch changed on stack operation");

    a_self_read_zero: assert property (acc_req && ind_self && !acc_wr
        |=> file_rd_zero_q && !file_rd_en_q)
        else $error("self indirect read not zero");

    a_self_write_drop: assert property (acc_req && ind_self && acc_wr
        |=> !file_wr_en_q && !file_rd_zero_q)
        else $error("self indirect write not dropped");

    a_ind_addr_form: assert property (acc_req && is_indirect && !ind_self
        |=> file_addr_q == {$past(indirect_bank_select), $past(file_select_pointer_q)}
            && (file_rd_en_q || file_wr_en_q))
        else $error("indirect address not bank over pointer");

    ////////////////////////////////////////////////////////////////////////////////

    // Helper for checks: no load that outranks a plain step this cycle
    logic no_load;
    assign no_load = ~intr_go & ~page_go & ~pop_any & ~pcl_wr;

    a_low_byte_write: assert property (pcl_wr && !intr_go && !page_go && !pop_any
        |=> pc_low_byte == $past(pcl_wdata))
        else $error("low byte write did not land");

    a_pc_step_inc: assert property (no_load && pc_step
        |=> pc_q == $past(pc_q) + PC_STEP)
        else $error("counter did not advance by one");

    a_pc_hold_idle: assert property (no_load && !pc_step |=> $stable(pc_q))
        else $error("counter moved without a request");

    a_intr_vector_load: assert property (intr_go |=> pc_q == INTR_VECTOR)
        else $error("interrupt did not load the vector");

    // Two nested calls unwound in turn must come back to where the first call stood
    a_call_ret_nested: assert property (s_call ##1 s_call ##1 s_return ##1 s_return
        |=> pc_q == $past(pc_q, 4))
        else $error("nested returns out of order");

    a_latch_write: assert property (latch_wr
        |=> pc_high_latch_q == $past(latch_wdata))
        else $error("latch write did not land");

    a_latch_hold: assert property (!latch_wr |=> $stable(pc_high_latch_q))
        else $error("latch changed without a write");

    a_ptr_write: assert property (fsr_wr
        |=> file_select_pointer_q == $past(fsr_wdata))
        else $error("pointer write did not land");

    a_ptr_hold: assert property (!fsr_wr |=> $stable(file_select_pointer_q))
        else $error("pointer changed without a write");

    a_direct_addr: assert property (acc_req
        && acc_addr[FILE_LOW_W-1:0] != INDIRECT_REG
        |=> file_addr_q == $past(acc_addr) && !file_rd_zero_q
            && file_rd_en_q == !$past(acc_wr) && file_wr_en_q == $past(acc_wr))
        else $error("direct access not passed through");

    a_no_access_idle: assert property (!acc_req
        |=> !file_rd_en_q && !file_wr_en_q && !file_rd_zero_q)
        else $error("access enable without a request");

    // The self case is judged on the pointer alone, whatever the bank bit says
    a_self_any_bank: assert property (acc_req
        && acc_addr[FILE_LOW_W-1:0] == INDIRECT_REG && file_select_pointer_q == SELF_PTR
        |=> !file_rd_en_q && !file_wr_en_q)
        else $error("self access reached the register file");

endmodule

// File: core/pcs_pkg.sv
package pcs_pkg;
    // Widths and stack depth
    localparam int PC_W        = 13;
    localparam int BYTE_W      = 8;
    localparam int UPPER_W     = 5;
    localparam int JUMP_W      = 11;
    localparam int STK_DEPTH   = 8;
    localparam int STK_IDX_W   = 3;
    localparam int FILE_ADDR_W = 9;
    localparam int FILE_LOW_W  = 7;

    // Field positions within the high latch
    localparam int PAGE_HI = 4;
    localparam int PAGE_LO = 3;

    // Reset values, step sizes and fixed addresses
    localparam logic [PC_W-1:0]       PC_RESET     = 13'h0000;
    localparam logic [PC_W-1:0]       PC_STEP      = 13'h0001;
    localparam logic [PC_W-1:0]       INTR_VECTOR  = 13'h0004;
    localparam logic [UPPER_W-1:0]    LATCH_RESET  = 5'h00;
    localparam logic [BYTE_W-1:0]     FSR_RESET    = 8'h00;
    localparam logic [BYTE_W-1:0]     SELF_PTR     = 8'h00;
    localparam logic [FILE_LOW_W-1:0] INDIRECT_REG = 7'h00;
    localparam logic [STK_IDX_W-1:0]  IDX_RESET    = 3'h0;
    localparam logic [STK_IDX_W-1:0]  IDX_STEP     = 3'h1;
endpackage

// File: core/pcs_ret_stack.sv
`timescale 1ns/1ps
module pcs_ret_stack
    import pcs_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // Stack operations
    input  wire logic            push,
    input  wire logic            pop,
    input  wire logic [PC_W-1:0] push_data,
    output logic      [PC_W-1:0] top_data
);

    logic [STK_IDX_W-1:0] idx_q;
    logic [STK_IDX_W-1:0] idx_d;
    logic [STK_IDX_W-1:0] top_idx;
    logic [PC_W-1:0]      entry_q [STK_DEPTH];

    // Index wraps both ways; no overflow or underflow is ever flagged
    assign top_idx  = idx_q - IDX_STEP;
    assign idx_d    = push ? idx_q + IDX_STEP
                    : pop  ? top_idx : idx_q;
    assign top_data = entry_q[top_idx];

    // Hidden index, never leaves this module
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q <= IDX_RESET;
        end else begin
            idx_q <= idx_d;
        end
    end

    // One flop word per entry; a push overwrites the oldest after eight
    genvar gi;
    generate
        for (gi = 0; gi < STK_DEPTH; gi++) begin : g_entry
            always_ff @(posedge clk or negedge rst_n) begin
                if (!rst_n) begin
                    entry_q[gi] <= PC_RESET;
                end else if (push && idx_q == STK_IDX_W'(gi)) begin
                    entry_q[gi] <= push_data;
                end
            end
        end
    endgenerate

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_push_wraps_idx: assert property (push |=> idx_q == $past(idx_q) + IDX_STEP)
        else $error("stack index did not advance on push");
    a_pop_wraps_idx: assert property (pop && !push |=> idx_q == $past(top_idx))
        else $error("stack index did not retreat on pop");

endmodule

// File: test/pcs_exec_model.sv
`timescale 1ns/1ps
module pcs_exec_model
    import pcs_pkg::*;
(
    // Operation picked by the sequencer
    input  wire logic [3:0] op,
    // Flow pulses towards the core
    output logic            pc_step,
    output logic            pcl_wr,
    output logic            jump_go,
    output logic            call_go,
    output logic            intr_go,
    output logic            ret_go,
    output logic            return_with_literal_go,
    output logic            return_from_interrupt_go
);
    ////////////////////////////////////////////////////////////////////////////
    // One-hot decode: a real core issues a single flow request per cycle
    assign pc_step   = (op == 4'h1);
    assign pcl_wr    = (op == 4'h2);
    assign jump_go   = (op == 4'h3);
    assign call_go   = (op == 4'h4);
    assign intr_go   = (op == 4'h5);
    assign ret_go    = (op == 4'h6);
    assign return_with_literal_go  = (op == 4'h7);
    assign return_from_interrupt_go = (op == 4'h8);
endmodule

// File: test/tb_pc_stack_indirect_addr.sv
`timescale 1ns/1ps
module tb_pc_stack_indirect_addr;
    import pcs_pkg::*;
    logic                   clk = 1'b0;
    logic                   rst_n = 1'b0;
    logic [3:0]             op = 4'h0;
    logic                   pc_step, pcl_wr, jump_go, call_go;
    logic                   intr_go, ret_go, return_with_literal_go, return_from_interrupt_go;
    logic                   latch_wr = 1'b0, fsr_wr = 1'b0, bank = 1'b0;
    logic                   acc_req = 1'b0, acc_wr = 1'b0;
    logic [BYTE_W-1:0]      wdata = 8'h00;
    logic [JUMP_W-1:0]      jump_addr = 11'h000;
    logic [FILE_ADDR_W-1:0] acc_addr = 9'h000;
    logic [PC_W-1:0]        pc_q, m_pc;
    logic [PC_W-1:0]        m_stk [STK_DEPTH];
    logic [UPPER_W-1:0]     pc_high_latch_q, m_lat;
    logic [BYTE_W-1:0]      file_select_pointer_q, m_ptr;
    logic [FILE_ADDR_W-1:0] file_addr_q, m_addr;
    logic                   file_rd_en_q, file_wr_en_q, file_rd_zero_q;
    logic                   m_rd, m_wr, m_z;
    logic [STK_IDX_W-1:0]   m_idx;
    logic [31:0]            r;
    logic [3:0]             o;
    integer                 seed = 74448, n_errors = 0, n_compared = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Clock, far-side model and design
    always #5 clk = ~clk;
    pcs_exec_model u_exec (.op(op), .pc_step(pc_step), .pcl_wr(pcl_wr), .jump_go(jump_go),
        .call_go(call_go), .intr_go(intr_go), .ret_go(ret_go), .return_with_literal_go(return_with_literal_go),
        .return_from_interrupt_go(return_from_interrupt_go));
    pcs_flow_core DUT (.clk(clk), .rst_n(rst_n), .pc_step(pc_step), .pcl_wr(pcl_wr),
        .pcl_wdata(wdata), .latch_wr(latch_wr), .latch_wdata(wdata[4:0]), .jump_go(jump_go),
        .call_go(call_go), .jump_addr(jump_addr), .intr_go(intr_go), .ret_go(ret_go),
        .return_with_literal_go(return_with_literal_go), .return_from_interrupt_go(return_from_interrupt_go), .fsr_wr(fsr_wr), .fsr_wdata(wdata),
        .indirect_bank_select(bank), .acc_req(acc_req), .acc_wr(acc_wr), .acc_addr(acc_addr),
        .pc_q(pc_q), .pc_high_latch_q(pc_high_latch_q),
        .file_select_pointer_q(file_select_pointer_q), .file_addr_q(file_addr_q),
        .file_rd_en_q(file_rd_en_q), .file_wr_en_q(file_wr_en_q),
        .file_rd_zero_q(file_rd_zero_q));

    ////////////////////////////////////////////////////////////////////////////
    // Expectation helpers: the self case ignores the bank bit
    function automatic logic f_self(input logic [8:0] aa, input logic [7:0] ptr);
        return (aa[6:0] == INDIRECT_REG) && (ptr == SELF_PTR);
    endfunction
    function automatic logic [8:0] f_addr(input logic [8:0] aa, input logic bk,
                                          input logic [7:0] ptr);
        return (aa[6:0] == INDIRECT_REG) ? {bk, ptr} : aa;
    endfunction

    task chk_val(input string name, input logic [12:0] e, input logic [12:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, e, g);
        end
    endtask
    task chk_flag(input string name, input logic e, input logic g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("wrong value %s expected %b seen %b", name, e, g);
        end
    endtask

    task model_reset;
        m_pc = PC_RESET;
        m_lat = LATCH_RESET;
        m_ptr = FSR_RESET;
        m_idx = IDX_RESET;
        m_addr = 9'h000;
        {m_rd, m_wr, m_z} = 3'b000;
        for (int i = 0; i < STK_DEPTH; i++) begin
            m_stk[i] = PC_RESET;
        end
    endtask

    task check_all;
        chk_val("pc", m_pc, pc_q); // Counter
        chk_val("latch", {8'h00, m_lat}, {8'h00, pc_high_latch_q}); // Latch
        chk_val("pointer", {5'h00, m_ptr}, {5'h00, file_select_pointer_q}); // Pointer
        chk_val("addr", {4'h0, m_addr}, {4'h0, file_addr_q}); // Address
        chk_flag("rd_en", m_rd, file_rd_en_q); // Read
        chk_flag("wr_en", m_wr, file_wr_en_q); // Write
        chk_flag("rd_zero", m_z, file_rd_zero_q); // Zero read
    endtask

    // One cycle: check the last result, drive at the falling edge, predict the next
    task step(input logic [3:0] oc, input logic lw, fw, ar, aw, input logic [7:0] d,
              input logic [10:0] ja, input logic [8:0] aa);
        @(negedge clk);
        check_all; // Last cycle's results
        op = oc;
        latch_wr = lw;
        fsr_wr = fw;
        acc_req = ar;
        acc_wr = aw;
        wdata = d;
        jump_addr = ja;
        acc_addr = aa;
        bank = 1'($random(seed));
        {m_rd, m_wr, m_z} = 3'b000;
        // The resolved address is refreshed every cycle, request or not
        m_addr = f_addr(aa, bank, m_ptr);
        if (ar) begin
            m_z = f_self(aa, m_ptr) && !aw;
            m_rd = !f_self(aa, m_ptr) && !aw;
            m_wr = !f_self(aa, m_ptr) && aw;
        end
        case (oc)
            4'h1: m_pc = m_pc + PC_STEP;
            4'h2: m_pc = {m_lat, d};
            4'h3: m_pc = {m_lat[PAGE_HI:PAGE_LO], ja};
            4'h4, 4'h5: begin
                m_stk[m_idx] = m_pc;
                m_idx = m_idx + IDX_STEP;
                m_pc = (oc == 4'h4) ? {m_lat[PAGE_HI:PAGE_LO], ja} : INTR_VECTOR;
            end
            4'h6, 4'h7, 4'h8: begin
                m_idx = m_idx - IDX_STEP;
                m_pc = m_stk[m_idx];
            end
            default: ;
        endcase
        if (lw) m_lat = d[4:0];
        if (fw) m_ptr = d;
    endtask

    task tally_and_finish;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: the sequence needs about 3060 cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        model_reset;
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        step(4'h0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h1f, 11'h000, 9'h000); // Reset state
        // Ten nested calls then ten mixed returns: wraps the eight entries
        for (int i = 0; i < 10; i++) begin
            step(4'h4, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 11'(i * 100 + 7), 9'h000);
        end
        for (int i = 0; i < 10; i++) begin
            step(4'h6 + 4'(i % 3), 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 11'h000, 9'h000);
        end
        step(4'h5, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 11'h000, 9'h000); // Vector
        step(4'h8, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 11'h000, 9'h000);
        step(4'h2, 1'b0, 1'b0, 1'b0, 1'b0, 8'hab, 11'h000, 9'h000); // In one block
        step(4'h3, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 11'h5a5, 9'h000); // Jump
        // Self access: zero read, silent write, pointer change racing a read
        step(4'h0, 1'b0, 1'b1, 1'b0, 1'b0, 8'h00, 11'h000, 9'h000);
        step(4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 11'h000, 9'h100);
        step(4'h0, 1'b0, 1'b0, 1'b1, 1'b1, 8'h00, 11'h000, 9'h000);
        step(4'h0, 1'b0, 1'b1, 1'b1, 1'b0, 8'h25, 11'h000, 9'h080);
        step(4'h0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00, 11'h000, 9'h000);
        for (int i = 0; i < 3000; i++) begin
            if (i == 1500) begin
                @(negedge clk);
                {op, latch_wr, fsr_wr, acc_req} = 7'h00;
                // Idle address and bank, so the first resolved address after reset is zero
                acc_addr = 9'h000;
                bank = 1'b0;
                rst_n = 1'b0;
                model_reset;
                repeat (3) @(negedge clk);
                rst_n = 1'b1;
            end
            o = 4'($unsigned($random(seed)) % 9);
            r = $random(seed);
            step(o, r[0] && (o < 4'h2 || o > 4'h4), r[1], r[2], r[3], r[15:8], r[26:16],
                 {r[31:30], r[5] ? 7'h00 : r[12:6]});
        end
        step(4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00, 11'h000, 9'h000);
        tally_and_finish;
    end
endmodule
